// File: rtl/operand_cache_pkg.sv
package operand_cache_pkg;
	// geometry: addresses count halfwords
	localparam int ADDR_W = 32;
	localparam int HW_W = 18;
	localparam int QW_W = 9;
	localparam int WORD_W = 36;
	localparam int DW_W = 72;
	localparam int QUAD_W = 144;
	localparam int LANES = 8;
	localparam int LANE_W = 3;
	localparam int WAYS = 4;
	localparam int WAY_W = 2;
	localparam int CACHE_WORDS = 16384;
	localparam int LINE_WORDS = 16;
	localparam int SETS = 256;
	localparam int SET_W = 8;
	localparam int SET_LSB = 5;
	localparam int ROWS = 1024;
	localparam int ROW_W = 10;
	localparam int ROW_LSB = 3;
	localparam int TAG_LSB = 13;
	localparam int TAG_W = ADDR_W - TAG_LSB;
	localparam int QEN_W = 16;
	localparam int RF_QEN_W = 8;
	localparam int RF_DEPTH_DEF = 256;
	// reset values
	localparam logic [QUAD_W-1:0] QUAD_RST = 144'h0;
	localparam logic [DW_W-1:0] DW_RST = 72'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0;

	// miss handling states
	typedef enum logic [1:0] {
		ST_LOOKUP = 2'h1,
		ST_WAIT_FILL = 2'h2
	} miss_state_t;

	// operand leg source choice
	typedef enum logic [3:0] {
		LEG_CACHE = 4'h1,
		LEG_CACHE_SWAP = 4'h2,
		LEG_REGFILE = 4'h4,
		LEG_IMMEDIATE = 4'h8
	} leg_sel_t;
endpackage : operand_cache_pkg

// File: rtl/halfword_bank.sv
`timescale 1ns/1ps
module halfword_bank (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// read port
	input wire logic rd_en,
	input wire logic [operand_cache_pkg::ROW_W-1:0] rd_row,
	input wire logic [operand_cache_pkg::WAYS-1:0] rd_hit,
	output logic [operand_cache_pkg::HW_W-1:0] rd_data,
	// write port
	input wire logic wr_en,
	input wire logic [operand_cache_pkg::ROW_W-1:0] wr_row,
	input wire logic [operand_cache_pkg::WAYS-1:0] wr_hit,
	input wire logic [1:0] wr_qen,
	input wire logic [operand_cache_pkg::HW_W-1:0] wr_data
);
	import operand_cache_pkg::*;

	// four ways of 1024 halfwords each
	logic [HW_W-1:0] mem [0:WAYS*ROWS-1];

	// one-hot hit lines to way number
	function automatic logic [WAY_W-1:0] way_of(input logic [WAYS-1:0] hit);
		way_of = '0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (hit[w])
				way_of = WAY_W'(w);
		end
	endfunction : way_of

	// quarter-word write strobes
	always_ff @(posedge core_clk)
	begin
		if (wr_en && |wr_hit)
		begin
			for (int q = 0; q < 2; q++)
			begin
				if (wr_qen[q])
					mem[{way_of(wr_hit), wr_row}][q*QW_W +: QW_W] <= wr_data[q*QW_W +: QW_W];
			end
		end
	end

	// registered read of the hitting way
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= (|rd_hit) ? mem[{way_of(rd_hit), rd_row}] : '0;
	end
endmodule : halfword_bank

// File: rtl/operand_data_cache.sv
// Behaviour
// - 16K words, four-word read and write
// - halfword organised, read starts any halfword
// - write any halfword start, quarter enables
// - four-way set-associative, sixteen-word lines
// - two tag copies cover straddling reads
// - eight-halfword rotator, output high/low aligned
// - tag stage compares start and end addresses
// - either copy missing means miss, then refill
// - eight four-way halfword banks of 1024
// - thermometer: ones from addressed halfword upward
// - thermometer picks hit vector and row
// - writes use queue addresses, commit stage
// - writes probed first as reads
// - write data from results or fill lines
// - register files written from upper two words
// - each leg picks cache, regfile or immediate
// - extra leg input: cache doubleword swapped
// - legs carry doublewords to operand queue
// - vector operations barred from register operands
`timescale 1ns/1ps
module operand_data_cache #(
	parameter int RF_DEPTH = operand_cache_pkg::RF_DEPTH_DEF,
	parameter int RF_AW = $clog2(RF_DEPTH)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// request from address pipeline
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] start_phys_addr,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] end_phys_addr,
	input wire logic req_write_probe,
	input wire logic req_vector,
	input wire operand_cache_pkg::leg_sel_t leg_one_sel,
	input wire operand_cache_pkg::leg_sel_t leg_two_sel,
	input wire logic [RF_AW-1:0] rf_raddr_one,
	input wire logic [RF_AW-1:0] rf_raddr_two,
	input wire logic [operand_cache_pkg::DW_W-1:0] imm_data,
	// memory sequencer
	output logic miss_req,
	output logic [operand_cache_pkg::ADDR_W-1:0] miss_addr,
	input wire logic fill_done,
	input wire logic fill_valid,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] fill_addr,
	input wire logic [operand_cache_pkg::WAY_W-1:0] fill_way,
	input wire logic fill_tag_we,
	input wire logic [operand_cache_pkg::QUAD_W-1:0] fill_data,
	// write queue
	input wire logic wq_valid,
	output logic wq_ready,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] wq_start_addr,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] wq_end_addr,
	input wire logic [operand_cache_pkg::WAYS-1:0] wq_start_hit,
	input wire logic [operand_cache_pkg::WAYS-1:0] wq_end_hit,
	input wire logic [operand_cache_pkg::QUAD_W-1:0] wq_data,
	input wire logic [operand_cache_pkg::QEN_W-1:0] wq_qen,
	// register file write from even/odd result lines
	input wire logic rf_we,
	input wire logic [RF_AW-1:0] rf_waddr,
	input wire logic [operand_cache_pkg::RF_QEN_W-1:0] rf_qen,
	input wire logic [operand_cache_pkg::QUAD_W-1:0] result_data,
	// operand queue
	output logic [operand_cache_pkg::DW_W-1:0] operand_leg_one,
	output logic [operand_cache_pkg::DW_W-1:0] operand_leg_two,
	output logic legs_valid,
	output logic legs_vector,
	output logic write_probe_ok,
	output logic vector_rf_fault
);
	import operand_cache_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// ones from the addressed halfword upward
	function automatic logic [LANES-1:0] therm(input logic [LANE_W-1:0] off);
		therm = '0;
		for (int i = 0; i < LANES; i++)
			therm[i] = (LANE_W'(i) >= off);
	endfunction : therm

	// aligned halfwords (first one highest) into bank lanes
	function automatic logic [QUAD_W-1:0] to_lanes(input logic [QUAD_W-1:0] src, input logic [LANE_W-1:0] off);
		logic [LANE_W-1:0] k;
		to_lanes = '0;
		for (int i = 0; i < LANES; i++)
		begin
			k = LANE_W'(i) - off;
			to_lanes[i*HW_W +: HW_W] = src[QUAD_W-1-k*HW_W -: HW_W];
		end
	endfunction : to_lanes

	// quarter enables follow their halfwords
	function automatic logic [QEN_W-1:0] qen_lanes(input logic [QEN_W-1:0] src, input logic [LANE_W-1:0] off);
		logic [LANE_W-1:0] k;
		qen_lanes = '0;
		for (int i = 0; i < LANES; i++)
		begin
			k = LANE_W'(i) - off;
			qen_lanes[i*2 +: 2] = src[QEN_W-1-k*2 -: 2];
		end
	endfunction : qen_lanes

	// bank lanes back into high/low aligned order
	function automatic logic [QUAD_W-1:0] from_lanes(input logic [QUAD_W-1:0] lanes, input logic [LANE_W-1:0] off);
		logic [LANE_W-1:0] i;
		from_lanes = '0;
		for (int k = 0; k < LANES; k++)
		begin
			i = LANE_W'(k) + off;
			from_lanes[QUAD_W-1-k*HW_W -: HW_W] = lanes[i*HW_W +: HW_W];
		end
	endfunction : from_lanes

	// leg source multiplexer
	function automatic logic [DW_W-1:0] leg_pick(input leg_sel_t sel, input logic [DW_W-1:0] cdw,
		input logic [DW_W-1:0] rdw, input logic [DW_W-1:0] imm, input logic vec);
		case (sel)
			LEG_CACHE: leg_pick = cdw;
			LEG_CACHE_SWAP: leg_pick = {cdw[WORD_W-1:0], cdw[DW_W-1:WORD_W]};
			LEG_REGFILE: leg_pick = vec ? DW_RST : rdw;
			LEG_IMMEDIATE: leg_pick = imm;
			default: leg_pick = DW_RST;
		endcase
	endfunction : leg_pick

	////////////////////////////////////////////////////////////////////////
	// tag arrays: two identical copies, four ways each

	logic [TAG_W-1:0] tag_mem [0:1][0:WAYS-1][0:SETS-1];
	logic [SETS-1:0] tag_vld_reg [0:1][0:WAYS-1];

	// valid bit and stored tag against the address
	function automatic logic tag_match(input logic v, input logic [TAG_W-1:0] t, input logic [ADDR_W-1:0] a);
		tag_match = v && (t == a[ADDR_W-1:TAG_LSB]);
	endfunction : tag_match

	// line fill writes both copies alike
	always_ff @(posedge core_clk)
	begin
		for (int c = 0; c < 2; c++)
		begin
			if (fill_tag_we)
				tag_mem[c][fill_way][fill_addr[SET_LSB +: SET_W]] <= fill_addr[ADDR_W-1:TAG_LSB];
		end
	end

	// valid bits cleared by reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int c = 0; c < 2; c++)
				for (int w = 0; w < WAYS; w++)
					tag_vld_reg[c][w] <= '0;
		end
		else if (fill_tag_we)
		begin
			for (int c = 0; c < 2; c++)
				tag_vld_reg[c][fill_way][fill_addr[SET_LSB +: SET_W]] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tag lookup stage

	logic tag_valid_reg;
	logic [ADDR_W-1:0] tag_start_reg;
	logic [ADDR_W-1:0] tag_end_reg;
	logic tag_probe_reg;
	logic tag_vector_reg;
	leg_sel_t tag_sel_one_reg;
	leg_sel_t tag_sel_two_reg;
	logic [RF_AW-1:0] tag_rf_one_reg;
	logic [RF_AW-1:0] tag_rf_two_reg;
	logic [DW_W-1:0] tag_imm_reg;
	logic [WAYS-1:0] hit_start;
	logic [WAYS-1:0] hit_end;
	logic tag_miss;
	logic advance;
	miss_state_t state_reg;

	// copy 0 looks up the start line, copy 1 the end line
	for (genvar w = 0; w < WAYS; w++)
	begin : g_way
		assign hit_start[w] = tag_match(tag_vld_reg[0][w][tag_start_reg[SET_LSB +: SET_W]],
			tag_mem[0][w][tag_start_reg[SET_LSB +: SET_W]], tag_start_reg);
		assign hit_end[w] = tag_match(tag_vld_reg[1][w][tag_end_reg[SET_LSB +: SET_W]],
			tag_mem[1][w][tag_end_reg[SET_LSB +: SET_W]], tag_end_reg);
	end
	assign tag_miss = tag_valid_reg && !(|hit_start && |hit_end);
	assign advance = tag_valid_reg && (state_reg == ST_LOOKUP) && !tag_miss;
	assign req_ready = !tag_valid_reg || advance;

	// request held here until both lines are resident
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tag_valid_reg <= 1'b0;
			tag_start_reg <= ADDR_RST;
			tag_end_reg <= ADDR_RST;
			tag_probe_reg <= 1'b0;
			tag_vector_reg <= 1'b0;
			tag_sel_one_reg <= LEG_CACHE;
			tag_sel_two_reg <= LEG_CACHE;
			tag_rf_one_reg <= '0;
			tag_rf_two_reg <= '0;
			tag_imm_reg <= DW_RST;
		end
		else if (req_ready)
		begin
			tag_valid_reg <= req_valid;
			if (req_valid)
			begin
				tag_start_reg <= start_phys_addr;
				tag_end_reg <= end_phys_addr;
				tag_probe_reg <= req_write_probe;
				tag_vector_reg <= req_vector;
				tag_sel_one_reg <= leg_one_sel;
				tag_sel_two_reg <= leg_two_sel;
				tag_rf_one_reg <= rf_raddr_one;
				tag_rf_two_reg <= rf_raddr_two;
				tag_imm_reg <= imm_data;
			end
		end
	end

	// miss sequencing: wait for the fill, then repeat the lookup
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= ST_LOOKUP;
		else
			case (state_reg)
				ST_LOOKUP: if (tag_miss) state_reg <= ST_WAIT_FILL;
				ST_WAIT_FILL: if (fill_done) state_reg <= ST_LOOKUP;
				default: state_reg <= ST_LOOKUP;
			endcase
	end

	// one-cycle miss request with the missing line base
	logic miss_req_reg;
	logic [ADDR_W-1:0] miss_addr_reg;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			miss_req_reg <= 1'b0;
			miss_addr_reg <= ADDR_RST;
		end
		else
		begin
			miss_req_reg <= (state_reg == ST_LOOKUP) && tag_miss;
			if ((state_reg == ST_LOOKUP) && tag_miss)
				miss_addr_reg <= |hit_start ? {tag_end_reg[ADDR_W-1:SET_LSB], {SET_LSB{1'b0}}}
					: {tag_start_reg[ADDR_W-1:SET_LSB], {SET_LSB{1'b0}}};
		end
	end

	assign miss_req = miss_req_reg;
	assign miss_addr = miss_addr_reg;

	////////////////////////////////////////////////////////////////////////
	// halfword banks: read lanes and write lanes

	logic [LANES-1:0] rd_therm;
	logic [LANES-1:0] wq_therm;
	logic [QUAD_W-1:0] rd_lanes;
	logic [QUAD_W-1:0] wr_lanes;
	logic [QEN_W-1:0] wr_qen;
	logic [WAYS-1:0] fill_hit;
	logic wq_take;
	logic wr_any;

	assign rd_therm = therm(tag_start_reg[LANE_W-1:0]);
	assign wq_therm = therm(wq_start_addr[LANE_W-1:0]);
	assign fill_hit = 4'h1 << fill_way;
	// fills win; queued writes wait for as long as fill_valid is high
	assign wq_ready = !fill_valid;
	assign wq_take = wq_valid && !fill_valid;
	assign wr_any = fill_valid || wq_take;
	// fill lines are four-word aligned, result lines rotate into place
	assign wr_lanes = fill_valid ? to_lanes(fill_data, 3'h0)
		: to_lanes(wq_data, wq_start_addr[LANE_W-1:0]);
	assign wr_qen = fill_valid ? {QEN_W{1'b1}} : qen_lanes(wq_qen, wq_start_addr[LANE_W-1:0]);

	for (genvar i = 0; i < LANES; i++)
	begin : g_lane
		logic [ROW_W-1:0] rd_row;
		logic [WAYS-1:0] rd_hit;
		logic [ROW_W-1:0] wr_row;
		logic [WAYS-1:0] wr_hit;

		// start lookup above the thermometer edge, end lookup below it
		assign rd_row = rd_therm[i] ? tag_start_reg[ROW_LSB +: ROW_W] : tag_end_reg[ROW_LSB +: ROW_W];
		assign rd_hit = rd_therm[i] ? hit_start : hit_end;
		// queued write: location stays resident, so its hit lines hold
		assign wr_row = fill_valid ? fill_addr[ROW_LSB +: ROW_W]
			: (wq_therm[i] ? wq_start_addr[ROW_LSB +: ROW_W] : wq_end_addr[ROW_LSB +: ROW_W]);
		assign wr_hit = fill_valid ? fill_hit : (wq_therm[i] ? wq_start_hit : wq_end_hit);

		halfword_bank u_bank (
			.core_clk(core_clk),
			.rst_b(rst_b),
			.rd_en(advance),
			.rd_row(rd_row),
			.rd_hit(rd_hit),
			.rd_data(rd_lanes[i*HW_W +: HW_W]),
			.wr_en(wr_any),
			.wr_row(wr_row),
			.wr_hit(wr_hit),
			.wr_qen(wr_qen[i*2 +: 2]),
			.wr_data(wr_lanes[i*HW_W +: HW_W])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// user register files: two copies of an even/odd pair

	logic [WORD_W-1:0] rf_even [0:1][0:RF_DEPTH-1];
	logic [WORD_W-1:0] rf_odd [0:1][0:RF_DEPTH-1];
	logic [DW_W-1:0] rf_dw_reg [0:1];

	// both copies take the upper two result words
	always_ff @(posedge core_clk)
	begin
		for (int c = 0; c < 2; c++)
			for (int q = 0; q < 4; q++)
			begin
				if (rf_we && rf_qen[4+q])
					rf_even[c][rf_waddr][q*QW_W +: QW_W] <= result_data[QUAD_W-WORD_W+q*QW_W +: QW_W];
				if (rf_we && rf_qen[q])
					rf_odd[c][rf_waddr][q*QW_W +: QW_W] <= result_data[DW_W+q*QW_W +: QW_W];
			end
	end

	// register operands read alongside the data banks
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rf_dw_reg[0] <= DW_RST;
			rf_dw_reg[1] <= DW_RST;
		end
		else if (advance)
		begin
			rf_dw_reg[0] <= {rf_even[0][tag_rf_one_reg], rf_odd[0][tag_rf_one_reg]};
			rf_dw_reg[1] <= {rf_even[1][tag_rf_two_reg], rf_odd[1][tag_rf_two_reg]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data read stage

	logic dr_valid_reg;
	logic [LANE_W-1:0] dr_off_reg;
	logic dr_probe_reg;
	logic dr_vector_reg;
	leg_sel_t dr_sel_one_reg;
	leg_sel_t dr_sel_two_reg;
	logic [DW_W-1:0] dr_imm_reg;
	logic [QUAD_W-1:0] rotated;
	logic dr_rf_bad;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dr_valid_reg <= 1'b0;
			dr_off_reg <= '0;
			dr_probe_reg <= 1'b0;
			dr_vector_reg <= 1'b0;
			dr_sel_one_reg <= LEG_CACHE;
			dr_sel_two_reg <= LEG_CACHE;
			dr_imm_reg <= DW_RST;
		end
		else
		begin
			dr_valid_reg <= advance;
			if (advance)
			begin
				dr_off_reg <= tag_start_reg[LANE_W-1:0];
				dr_probe_reg <= tag_probe_reg;
				dr_vector_reg <= tag_vector_reg;
				dr_sel_one_reg <= tag_sel_one_reg;
				dr_sel_two_reg <= tag_sel_two_reg;
				dr_imm_reg <= tag_imm_reg;
			end
		end
	end

	// first addressed halfword lands highest
	assign rotated = from_lanes(rd_lanes, dr_off_reg);
	assign dr_rf_bad = dr_vector_reg && (dr_sel_one_reg == LEG_REGFILE || dr_sel_two_reg == LEG_REGFILE);

	////////////////////////////////////////////////////////////////////////
	// operand legs to the operand queue

	logic [DW_W-1:0] leg_one_reg;
	logic [DW_W-1:0] leg_two_reg;
	logic legs_valid_reg;
	logic legs_vector_reg;
	logic probe_ok_reg;
	logic rf_fault_reg;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			leg_one_reg <= DW_RST;
			leg_two_reg <= DW_RST;
			legs_valid_reg <= 1'b0;
			legs_vector_reg <= 1'b0;
			probe_ok_reg <= 1'b0;
			rf_fault_reg <= 1'b0;
		end
		else
		begin
			legs_valid_reg <= dr_valid_reg && !dr_probe_reg;
			probe_ok_reg <= dr_valid_reg && dr_probe_reg;
			rf_fault_reg <= dr_valid_reg && !dr_probe_reg && dr_rf_bad;
			if (dr_valid_reg && !dr_probe_reg)
			begin
				legs_vector_reg <= dr_vector_reg;
				leg_one_reg <= leg_pick(dr_sel_one_reg, rotated[QUAD_W-1:DW_W], rf_dw_reg[0],
					dr_imm_reg, dr_vector_reg);
				leg_two_reg <= leg_pick(dr_sel_two_reg, rotated[DW_W-1:0], rf_dw_reg[1],
					dr_imm_reg, dr_vector_reg);
			end
		end
	end

	assign operand_leg_one = leg_one_reg;
	assign operand_leg_two = leg_two_reg;
	assign legs_valid = legs_valid_reg;
	assign legs_vector = legs_vector_reg;
	assign write_probe_ok = probe_ok_reg;
	assign vector_rf_fault = rf_fault_reg;
endmodule : operand_data_cache

// File: verif/operand_data_cache_assertions.sv
`timescale 1ns/1ps
module operand_cache_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// request and sequencer side
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic miss_req,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] miss_addr,
	input wire logic fill_done,
	input wire logic fill_valid,
	input wire logic wq_ready,
	// operand queue side
	input wire logic legs_valid,
	input wire logic legs_vector,
	input wire logic write_probe_ok,
	input wire logic vector_rf_fault,
	input wire logic [operand_cache_pkg::DW_W-1:0] operand_leg_one,
	input wire logic [operand_cache_pkg::DW_W-1:0] operand_leg_two
);
	import operand_cache_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	// a taken request is answered by a delivery or by a miss report
	sequence taken_s;
		req_valid && req_ready;
	endsequence
	sequence hit_answer_s;
		##3 (legs_valid || write_probe_ok);
	endsequence
	sequence miss_answer_s;
		##2 miss_req;
	endsequence
	AST_REQ_ANSWER: assert property (taken_s |-> hit_answer_s or miss_answer_s)
		else $error("request not answered at its latency");
	AST_MISS_PULSE: assert property (miss_req |=> !miss_req)
		else $error("miss report longer than one cycle");
	AST_MISS_LINE_BASE: assert property (miss_req |-> miss_addr[4:0] == 5'h0)
		else $error("miss address not a line base");
	AST_MISS_HOLDS: assert property (miss_req |-> !req_ready)
		else $error("new request accepted while a miss waits");
	AST_FILL_RETRY: assert property (fill_done |=> req_ready or ##1 miss_req)
		else $error("lookup not repeated after fill");
	AST_WQ_FILL_PRIO: assert property (wq_ready == !fill_valid)
		else $error("queue write not blocked by fill only");
	AST_FAULT_VECTOR: assert property (vector_rf_fault |-> legs_valid && legs_vector)
		else $error("register fault without vector delivery");
	AST_FAULT_ZERO: assert property (vector_rf_fault |-> operand_leg_one == '0 || operand_leg_two == '0)
		else $error("faulting leg not zeroed");
	AST_PROBE_SILENT: assert property (write_probe_ok |-> !legs_valid)
		else $error("write probe delivered operands");
endmodule : operand_cache_checker
bind operand_data_cache operand_cache_checker chk (.core_clk, .rst_b, .req_valid, .req_ready, .miss_req,
	.miss_addr, .fill_done, .fill_valid, .wq_ready, .legs_valid, .legs_vector, .write_probe_ok,
	.vector_rf_fault, .operand_leg_one, .operand_leg_two);

// File: verif/memory_sequencer_model.sv
`timescale 1ns/1ps
module memory_sequencer_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// idle cycles before each fill
	input wire logic [3:0] fill_delay,
	// miss request
	input wire logic miss_req,
	input wire logic [operand_cache_pkg::ADDR_W-1:0] miss_addr,
	// line fill
	output logic fill_done,
	output logic fill_valid,
	output logic [operand_cache_pkg::ADDR_W-1:0] fill_addr,
	output logic [operand_cache_pkg::WAY_W-1:0] fill_way,
	output logic fill_tag_we,
	output logic [operand_cache_pkg::QUAD_W-1:0] fill_data
);
	import operand_cache_pkg::*;
	logic [ADDR_W-1:0] line;
	logic [QUAD_W-1:0] beat;
	////////////////////////////////////////////////////////////////
	// backing store: each halfword is a fixed function of its address
	function automatic logic [HW_W-1:0] backing_hw(input logic [ADDR_W-1:0] a);
		return a[HW_W-1:0] ^ 18'h15a5a;
	endfunction : backing_hw
	// whole line in four beats, then done; way from low tag bits so no line is ever evicted
	initial
	begin
		{fill_done, fill_valid, fill_tag_we, fill_addr, fill_way, fill_data} = '0;
		forever
		begin
			@(posedge core_clk);
			if (rst_b === 1'b1 && miss_req === 1'b1)
			begin
				line = miss_addr;
				repeat (fill_delay) @(posedge core_clk);
				for (int b = 0; b < 4; b++)
				begin
					for (int k = 0; k < 8; k++)
						beat[QUAD_W-1-HW_W*k -: HW_W] = backing_hw(line + 32'(8 * b + k));
					fill_valid <= 1'b1;
					fill_tag_we <= 1'b1;
					fill_way <= line[14:13];
					fill_addr <= line + 32'(8 * b);
					fill_data <= beat;
					@(posedge core_clk);
				end
				fill_valid <= 1'b0;
				fill_tag_we <= 1'b0;
				fill_data <= ~beat; // released lines do not keep the last beat
				fill_done <= 1'b1;
				@(posedge core_clk);
				fill_done <= 1'b0;
			end
		end
	end
endmodule : memory_sequencer_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import operand_cache_pkg::*;
	typedef struct {logic [DW_W-1:0] one; logic [DW_W-1:0] two; logic probe; logic fault; logic vec;} exp_t;
	logic core_clk, rst_b, req_valid, req_ready, req_write_probe, req_vector, miss_req, fill_done, fill_valid;
	logic fill_tag_we, wq_valid, wq_ready, rf_we, legs_valid, legs_vector, write_probe_ok, vector_rf_fault;
	logic [ADDR_W-1:0] start_phys_addr, end_phys_addr, miss_addr, fill_addr, wq_start_addr, wq_end_addr;
	leg_sel_t leg_one_sel, leg_two_sel;
	logic [7:0] rf_raddr_one, rf_raddr_two, rf_waddr, rf_qen;
	logic [DW_W-1:0] imm_data, operand_leg_one, operand_leg_two;
	logic [WAY_W-1:0] fill_way;
	logic [WAYS-1:0] wq_start_hit, wq_end_hit;
	logic [QUAD_W-1:0] fill_data, wq_data, result_data;
	logic [QEN_W-1:0] wq_qen;
	logic [3:0] fill_delay;
	logic [31:0] rng = 32'he60699d5;
	logic [HW_W-1:0] mem [int];
	logic [DW_W-1:0] rf [256];
	exp_t exp_q [$];
	exp_t got;
	int error_cnt, total_checks;
	////////////////////////////////////////////////////////////////
	operand_data_cache #(.RF_DEPTH(256)) dut (.core_clk, .rst_b, .req_valid, .req_ready, .start_phys_addr,
		.end_phys_addr, .req_write_probe, .req_vector, .leg_one_sel, .leg_two_sel, .rf_raddr_one, .rf_raddr_two,
		.imm_data, .miss_req, .miss_addr, .fill_done, .fill_valid, .fill_addr, .fill_way, .fill_tag_we, .fill_data,
		.wq_valid, .wq_ready, .wq_start_addr, .wq_end_addr, .wq_start_hit, .wq_end_hit, .wq_data, .wq_qen, .rf_we,
		.rf_waddr, .rf_qen, .result_data, .operand_leg_one, .operand_leg_two, .legs_valid, .legs_vector,
		.write_probe_ok, .vector_rf_fault);
	memory_sequencer_model partner (.core_clk, .rst_b, .fill_delay, .miss_req, .miss_addr, .fill_done,
		.fill_valid, .fill_addr, .fill_way, .fill_tag_we, .fill_data);
	////////////////////////////////////////////////////////////////
	// model helpers
	function automatic logic [31:0] xorshift();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xorshift
	function automatic logic [HW_W-1:0] hw(input int a);
		return mem.exists(a) ? mem[a] : (18'(a) ^ 18'h15a5a);
	endfunction : hw
	function automatic logic [DW_W-1:0] leg(input leg_sel_t s, input logic [DW_W-1:0] c,
		input logic [DW_W-1:0] r, input logic [DW_W-1:0] im, input logic vec);
		case (s)
			LEG_CACHE: return c;
			LEG_CACHE_SWAP: return {c[35:0], c[71:36]};
			LEG_REGFILE: return vec ? '0 : r;
			default: return im;
		endcase
	endfunction : leg
	task automatic check(input logic [159:0] seen, input logic [159:0] want);
		total_checks++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic summarize();
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// hold the request until ready is seen high, then let the taking edge pass
	task automatic await_high(input logic use_wq);
		do
			@(negedge core_clk);
		while ((use_wq ? wq_ready : req_ready) !== 1'b1);
		@(posedge core_clk);
	endtask : await_high
	task automatic issue(input int a, input leg_sel_t s1, input leg_sel_t s2, input logic probe, input logic vec);
		exp_t e;
		logic [QUAD_W-1:0] q;
		logic [7:0] r1, r2;
		logic [DW_W-1:0] im;
		r1 = 8'(xorshift());
		r2 = 8'(xorshift());
		im = DW_W'({xorshift(), xorshift(), xorshift()});
		for (int k = 0; k < 8; k++)
			q[QUAD_W-1-HW_W*k -: HW_W] = hw(a + k);
		e.one = leg(s1, q[143:72], rf[r1], im, vec);
		e.two = leg(s2, q[71:0], rf[r2], im, vec);
		e.probe = probe;
		e.vec = vec;
		e.fault = vec && (s1 == LEG_REGFILE || s2 == LEG_REGFILE);
		fill_delay <= 4'(xorshift());
		req_valid <= 1'b1;
		start_phys_addr <= 32'(a);
		end_phys_addr <= 32'(a + 7);
		req_write_probe <= probe;
		req_vector <= vec;
		leg_one_sel <= s1;
		leg_two_sel <= s2;
		rf_raddr_one <= r1;
		rf_raddr_two <= r2;
		imm_data <= im;
		await_high(1'b0);
		exp_q.push_back(e);
	endtask : issue
	task automatic wq_write(input int a, input logic [QEN_W-1:0] qe);
		logic [QUAD_W-1:0] d;
		logic [HW_W-1:0] w;
		int b;
		b = a + 7;
		d = QUAD_W'({xorshift(), xorshift(), xorshift(), xorshift(), xorshift()});
		for (int k = 0; k < 8; k++)
		begin
			w = hw(a + k);
			if (qe[15 - 2 * k])
				w[17:9] = d[143 - 18 * k -: 9];
			if (qe[14 - 2 * k])
				w[8:0] = d[134 - 18 * k -: 9];
			mem[a + k] = w;
		end
		wq_valid <= 1'b1;
		wq_start_addr <= 32'(a);
		wq_end_addr <= 32'(b);
		wq_start_hit <= 4'h1 << a[14:13];
		wq_end_hit <= 4'h1 << b[14:13];
		wq_data <= d;
		wq_qen <= qe;
		await_high(1'b1);
	endtask : wq_write
	task automatic rf_write(input int r, input logic [7:0] qe);
		logic [QUAD_W-1:0] d;
		d = QUAD_W'({xorshift(), xorshift(), xorshift(), xorshift(), xorshift()});
		for (int q = 0; q < 8; q++)
			if (qe[q])
				rf[r][9 * q +: 9] = d[72 + 9 * q +: 9];
		rf_we <= 1'b1;
		rf_waddr <= 8'(r);
		rf_qen <= qe;
		result_data <= d;
		@(posedge core_clk);
	endtask : rf_write
	task automatic drain();
		for (int n = 0; n < 600 && exp_q.size() != 0; n++)
			@(posedge core_clk);
	endtask : drain
	////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#400000;
		error_cnt++;
		summarize();
	end
	// compare each delivery with the model queue
	always @(posedge core_clk)
	begin
		#1;
		if (legs_valid === 1'b1 || write_probe_ok === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(1'b1, 1'b0);
			else
			begin
				got = exp_q.pop_front();
				check({write_probe_ok, vector_rf_fault}, {got.probe, got.fault});
				if (!got.probe)
					check({legs_vector, operand_leg_one, operand_leg_two}, {got.vec, got.one, got.two});
			end
		end
	end
	// main sequence
	initial
	begin
		int a;
		{rst_b, req_valid, req_write_probe, req_vector, wq_valid, rf_we, fill_delay} = '0;
		{start_phys_addr, end_phys_addr, wq_start_addr, wq_end_addr, imm_data, wq_data, result_data} = '0;
		{rf_raddr_one, rf_raddr_two, rf_waddr, rf_qen, wq_start_hit, wq_end_hit, wq_qen} = '0;
		leg_one_sel = LEG_CACHE;
		leg_two_sel = LEG_CACHE;
		repeat (12) @(posedge core_clk);
		#1;
		check({req_ready, miss_req, legs_valid, write_probe_ok, vector_rf_fault}, 5'h10);
		@(posedge core_clk);
		rst_b <= 1'b1;
		for (int r = 0; r < 288; r++)
			rf_write(r < 256 ? r : int'(xorshift() % 256), r < 256 ? 8'hff : 8'(xorshift()));
		rf_we <= 1'b0;
		// every source on both legs, a vector register fault, then random back-to-back reads
		for (int j = 0; j < 4; j++)
			issue(24 * j + 27, leg_sel_t'(4'h1 << j), leg_sel_t'(4'h8 >> j), 1'b0, 1'b0);
		issue(61, LEG_REGFILE, LEG_CACHE_SWAP, 1'b0, 1'b1);
		for (int i = 0; i < 80; i++)
			issue(int'(xorshift() % 32760), leg_sel_t'(4'h1 << (xorshift() % 4)),
				leg_sel_t'(4'h1 << (xorshift() % 4)), i % 9 == 4, i % 5 == 2 && i % 9 != 4);
		req_valid <= 1'b0;
		drain();
		// probe, queue write at any halfword start, read back
		for (int i = 0; i < 16; i++)
		begin
			a = int'(xorshift() % 32760);
			issue(a, LEG_CACHE, LEG_CACHE, 1'b1, 1'b0);
			req_valid <= 1'b0;
			drain();
			wq_write(a, i == 0 ? 16'hffff : 16'(xorshift()));
			wq_valid <= 1'b0;
			issue(a, LEG_CACHE, LEG_CACHE_SWAP, 1'b0, 1'b0);
			req_valid <= 1'b0;
			drain();
		end
		check(exp_q.size(), 0);
		summarize();
	end
endmodule : tb_top
